// *** logic/scss_defs.svh ***
// Offsets, field positions, reset values and widths of the clock source selector.
// Assumes a 32-bit register port with byte addresses in 8 bits.
`ifndef SCSS_DEFS_SVH
`define SCSS_DEFS_SVH

`define SCSS_ADDR_W       8
`define SCSS_DATA_W       32
`define SCSS_OFF_SYSCTL   8'h00
`define SCSS_OFF_PLLCTL   8'h04
`define SCSS_OFF_PRESC    8'h08
`define SCSS_OFF_STATUS   8'h0C

`define SCSS_SEL_LSB      0
`define SCSS_SEL_MSB      1
`define SCSS_BYPASS_BIT   0
`define SCSS_OSCSEL_BIT   1
`define SCSS_PREDIV_LSB   2
`define SCSS_PREDIV_MSB   5
`define SCSS_MULT_LSB     6
`define SCSS_MULT_MSB     12
`define SCSS_POSTDIV_LSB  13
`define SCSS_POSTDIV_MSB  19
`define SCSS_PRESC_LSB    0
`define SCSS_PRESC_MSB    9

`define SCSS_ST_SEL_LSB   0
`define SCSS_ST_SEL_MSB   1
`define SCSS_ST_BYP_BIT   2
`define SCSS_ST_PEND_BIT  3
`define SCSS_ST_CLK_BIT   4

`define SCSS_SEL_WAKEUP   2'h0
`define SCSS_SEL_PLL      2'h2
`define SCSS_SEL_DIRECT   2'h3

`define SCSS_RST_SEL      2'h0
`define SCSS_RST_BYPASS   1'h1
`define SCSS_RST_OSCSEL   1'h0
`define SCSS_RST_PREDIV   4'h0
`define SCSS_RST_MULT     7'h00
`define SCSS_RST_POSTDIV  7'h00
`define SCSS_RST_PRESC    10'h000

`define SCSS_DIV_W        10
`define SCSS_PER_W        16
`define SCSS_THR_W        29

`define SCSS_PIN_DIRECT   0
`define SCSS_PIN_CRYSTAL  1
`define SCSS_PIN_INTERNAL 2
`define SCSS_PIN_WAKEUP   3

`endif

// *** logic/scss_pkg.sv ***
// Types and the mode decode shared by the clock source selector.
// Assumes scss_defs.svh is on the include path.
`include "scss_defs.svh"

package scss_pkg;

  typedef enum logic [1:0] {
    mode_wakeup,
    mode_prescale,
    mode_pll,
    mode_direct
  } scss_mode_t;

  // Code 01 is undocumented and held as wakeup so the field is fully decoded
  function automatic scss_mode_t scss_decode_mode(input logic [1:0] sel,
                                                  input logic       bypass);
    scss_mode_t m;
    m = mode_wakeup;
    case (sel)
      `SCSS_SEL_DIRECT: m = mode_direct;
      `SCSS_SEL_PLL:    m = bypass ? mode_prescale : mode_pll;
      default:          m = mode_wakeup;
    endcase
    return m;
  endfunction

endpackage

// *** logic/scss_div_if.sv ***
// Link between the selector and its edge-counting divider.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "scss_defs.svh"

interface scss_div_if;
  logic                   src_edge;
  logic [`SCSS_DIV_W-1:0] target;
  logic                   restart;
  logic                   toggle;

  modport ctrl (output src_edge, output target, output restart, input toggle);
  modport div  (input src_edge, input target, input restart, output toggle);
endinterface

`default_nettype wire

// *** logic/scss_edge_divider.sv ***
// Counts both edges of the selected source and flags every target+1-th one.
// Assumes the edge strobe is already synchronised to clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "scss_defs.svh"

module scss_edge_divider
  import scss_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  scss_div_if.div     dv
);

  logic [`SCSS_DIV_W-1:0] count_ff;
  logic                   wrap;

  // Counting both edges gives target+1 input half-periods per output phase
  assign wrap      = (count_ff == dv.target);
  assign dv.toggle = dv.src_edge && wrap;  // [RULE_04] [RULE_05]

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count_ff <= '0;
    end else if (dv.restart) begin
      count_ff <= '0;
    end else if (dv.src_edge) begin
      count_ff <= wrap ? '0 : count_ff + `SCSS_DIV_W'(1);
    end
  end

endmodule

`default_nettype wire

// *** logic/scss_clock_select.sv ***
// System clock source selector and divider, rebuilt as sampled logic on clk_i.
// Assumes source clocks well below half of clk_i; they are sampled, not used as clocks.
//
// What this block does
// RULE_01 - Select 11 drives clock from direct pin
// RULE_02 - Factor one passes input duty cycle through
// RULE_03 - Select 10 with bypass: prescaler mode
// RULE_04 - Prescaler divides by field plus one
// RULE_05 - Prescaler reaches divide factor of 1024
// RULE_06 - Crystal bypass factor one equals direct drive
// RULE_07 - Select 10, no bypass: PLL N/(P*K2)
// RULE_08 - Select 00 takes wakeup clock unchanged
// RULE_09 - Software changes frequency in small steps (not enforced here; any new setting is taken whole at one swap)
// RULE_10 - Source switches never cut clock phases
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "scss_defs.svh"

module scss_clock_select
  import scss_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic [`SCSS_ADDR_W-1:0]  addr_i,
  input  wire logic [`SCSS_DATA_W-1:0]  wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [`SCSS_DATA_W-1:0]  rdata_o,
  input  wire logic                     direct_clock_input_pin_i,
  input  wire logic                     crystal_input_pin_i,
  input  wire logic                     internal_clock_i,
  input  wire logic                     wakeup_clock_i,
  output logic                          sys_clk_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [1:0]             clock_source_select_ff;
  logic                   vco_bypass_ff;
  logic                   osc_sel_ff;
  logic [3:0]             pll_input_divide_field_ff;
  logic [6:0]             pll_multiply_field_ff;
  logic [6:0]             pll_output_divide_field_ff;
  logic [`SCSS_DIV_W-1:0] prescaler_divide_field_ff;
  logic [`SCSS_DATA_W-1:0] rdata_ff;
  logic [`SCSS_DATA_W-1:0] nxt_rdata;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clock_source_select_ff     <= `SCSS_RST_SEL;
      vco_bypass_ff              <= `SCSS_RST_BYPASS;
      osc_sel_ff                 <= `SCSS_RST_OSCSEL;
      pll_input_divide_field_ff  <= `SCSS_RST_PREDIV;
      pll_multiply_field_ff      <= `SCSS_RST_MULT;
      pll_output_divide_field_ff <= `SCSS_RST_POSTDIV;
      prescaler_divide_field_ff  <= `SCSS_RST_PRESC;
    end else if (wr_i) begin
      case (addr_i)
        `SCSS_OFF_SYSCTL: clock_source_select_ff <= wdata_i[`SCSS_SEL_MSB:`SCSS_SEL_LSB];
        `SCSS_OFF_PLLCTL: begin
          vco_bypass_ff              <= wdata_i[`SCSS_BYPASS_BIT];
          osc_sel_ff                 <= wdata_i[`SCSS_OSCSEL_BIT];
          pll_input_divide_field_ff  <= wdata_i[`SCSS_PREDIV_MSB:`SCSS_PREDIV_LSB];
          pll_multiply_field_ff      <= wdata_i[`SCSS_MULT_MSB:`SCSS_MULT_LSB];
          pll_output_divide_field_ff <= wdata_i[`SCSS_POSTDIV_MSB:`SCSS_POSTDIV_LSB];
        end
        `SCSS_OFF_PRESC:  prescaler_divide_field_ff <= wdata_i[`SCSS_PRESC_MSB:`SCSS_PRESC_LSB];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pins;
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] lvl_ff;
  logic [3:0] lvl_d_ff;
  logic [3:0] nxt_lvl;
  logic [3:0] edge_any;
  logic [3:0] rise;

  assign pins = {wakeup_clock_i, internal_clock_i, crystal_input_pin_i, direct_clock_input_pin_i};

  // A level is taken only once the second and third stage agree
  assign nxt_lvl  = (s2_ff & ~(s2_ff ^ s3_ff)) | (lvl_ff & (s2_ff ^ s3_ff));
  assign edge_any = lvl_ff ^ lvl_d_ff;
  assign rise     = lvl_ff & ~lvl_d_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_ff    <= 4'h0;
      s2_ff    <= 4'h0;
      s3_ff    <= 4'h0;
      lvl_ff   <= 4'h0;
      lvl_d_ff <= 4'h0;
    end else begin
      s1_ff    <= pins;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      lvl_ff   <= nxt_lvl;
      lvl_d_ff <= lvl_ff;
    end
  end

  // ****************************************************************
  // Active configuration and switch-over
  // ****************************************************************
  logic [1:0]             act_sel_ff;
  logic                   act_byp_ff;
  logic                   act_osc_ff;
  logic [3:0]             act_p_ff;
  logic [6:0]             act_n_ff;
  logic [6:0]             act_k2_ff;
  logic [`SCSS_DIV_W-1:0] act_k_ff;
  scss_mode_t             act_mode;
  scss_mode_t             pend_mode;
  logic                   cfg_diff;
  logic                   toggle;
  logic                   switch_now;
  logic                   sys_clk_ff;
  logic                   nxt_sys_clk;

  assign act_mode  = scss_decode_mode(act_sel_ff, act_byp_ff);
  assign pend_mode = scss_decode_mode(clock_source_select_ff, vco_bypass_ff);
  assign cfg_diff  = (pend_mode != act_mode) || (osc_sel_ff != act_osc_ff) ||
                     (pll_input_divide_field_ff != act_p_ff) ||
                     (pll_multiply_field_ff != act_n_ff) ||
                     (pll_output_divide_field_ff != act_k2_ff) ||
                     (prescaler_divide_field_ff != act_k_ff);

  // Swap only where the low phase would end, so no phase is cut short;
  // a dead old source holds the swap off until it runs again, except in PLL mode, where the rate generator keeps its last period
  assign switch_now  = cfg_diff && !sys_clk_ff && toggle;  // [RULE_10]
  assign nxt_sys_clk = switch_now ? 1'b0 : (sys_clk_ff ^ toggle);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      act_sel_ff <= `SCSS_RST_SEL;
      act_byp_ff <= `SCSS_RST_BYPASS;
      act_osc_ff <= `SCSS_RST_OSCSEL;
      act_p_ff   <= `SCSS_RST_PREDIV;
      act_n_ff   <= `SCSS_RST_MULT;
      act_k2_ff  <= `SCSS_RST_POSTDIV;
      act_k_ff   <= `SCSS_RST_PRESC;
    end else if (switch_now) begin  // [RULE_10]
      act_sel_ff <= clock_source_select_ff;
      act_byp_ff <= vco_bypass_ff;
      act_osc_ff <= osc_sel_ff;
      act_p_ff   <= pll_input_divide_field_ff;
      act_n_ff   <= pll_multiply_field_ff;
      act_k2_ff  <= pll_output_divide_field_ff;
      act_k_ff   <= prescaler_divide_field_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sys_clk_ff <= 1'b0;
    end else begin
      sys_clk_ff <= nxt_sys_clk;
    end
  end

  assign sys_clk_o = sys_clk_ff;

  // ****************************************************************
  // Divider path: direct, prescaler, wakeup
  // ****************************************************************
  scss_div_if div_link ();
  logic [1:0]             sel_pin;
  logic                   align_ff;

  assign sel_pin = (act_mode == mode_direct)   ? 2'(`SCSS_PIN_DIRECT) :   // [RULE_01] [RULE_02]
                   (act_mode != mode_prescale) ? 2'(`SCSS_PIN_WAKEUP) :   // [RULE_08]
                   act_osc_ff                  ? 2'(`SCSS_PIN_INTERNAL)   // [RULE_03] [RULE_06]
                                               : 2'(`SCSS_PIN_CRYSTAL);
  assign div_link.target = (act_mode == mode_prescale) ? act_k_ff : '0;  // [RULE_04] [RULE_05]

  // After a swap wait for a rise of the new source; a fall first would invert the duty
  assign div_link.src_edge = edge_any[sel_pin] && (!align_ff || rise[sel_pin]);  // [RULE_02]
  assign div_link.restart  = switch_now;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || switch_now) begin
      align_ff <= 1'b1;
    end else if (div_link.src_edge) begin
      align_ff <= 1'b0;
    end
  end

  scss_edge_divider u_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .dv      (div_link.div)
  );

  // ****************************************************************
  // PLL path: rate generator locked to the reference period
  // ****************************************************************
  // Output toggles at rate 2N/(period*P*K2) per cycle; at most one
  // toggle per cycle, so high ratios saturate near half of clk_i
  logic [`SCSS_PER_W-1:0] per_cnt_ff;
  logic [`SCSS_PER_W-1:0] period_ff;
  logic [`SCSS_THR_W-1:0] thr_ff;
  logic [`SCSS_THR_W-1:0] acc_ff;
  logic [`SCSS_THR_W-1:0] acc_sum;
  logic [`SCSS_THR_W-1:0] thr_calc;
  logic [4:0]             p_fac;
  logic [7:0]             k2_fac;
  logic [8:0]             step;
  logic                   ref_rise;
  logic                   pll_toggle;

  assign ref_rise   = act_osc_ff ? rise[`SCSS_PIN_INTERNAL] : rise[`SCSS_PIN_CRYSTAL];
  assign p_fac      = {1'b0, act_p_ff} + 5'h01;
  assign k2_fac     = {1'b0, act_k2_ff} + 8'h01;
  assign step       = {({1'b0, act_n_ff} + 8'h01), 1'b0};
  assign thr_calc   = period_ff * p_fac * k2_fac;  // [RULE_07]
  assign acc_sum    = acc_ff + {20'h00000, step};
  assign pll_toggle = (thr_ff != '0) && (acc_sum >= thr_ff);  // [RULE_07]
  assign toggle     = (act_mode == mode_pll) ? pll_toggle : div_link.toggle;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      per_cnt_ff <= '0;
      period_ff  <= '0;
    end else if (ref_rise) begin
      per_cnt_ff <= `SCSS_PER_W'(1);
      period_ff  <= per_cnt_ff;
    end else if (per_cnt_ff != '1) begin
      per_cnt_ff <= per_cnt_ff + `SCSS_PER_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      thr_ff <= '0;
    end else begin
      thr_ff <= thr_calc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_ff <= '0;
    end else if (switch_now || (act_mode != mode_pll)) begin
      acc_ff <= '0;
    end else if (pll_toggle) begin
      acc_ff <= acc_sum - thr_ff;  // [RULE_07]
    end else begin
      acc_ff <= acc_sum;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    nxt_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        `SCSS_OFF_SYSCTL: nxt_rdata[`SCSS_SEL_MSB:`SCSS_SEL_LSB] = clock_source_select_ff;
        `SCSS_OFF_PLLCTL: begin
          nxt_rdata[`SCSS_BYPASS_BIT]                    = vco_bypass_ff;
          nxt_rdata[`SCSS_OSCSEL_BIT]                    = osc_sel_ff;
          nxt_rdata[`SCSS_PREDIV_MSB:`SCSS_PREDIV_LSB]   = pll_input_divide_field_ff;
          nxt_rdata[`SCSS_MULT_MSB:`SCSS_MULT_LSB]       = pll_multiply_field_ff;
          nxt_rdata[`SCSS_POSTDIV_MSB:`SCSS_POSTDIV_LSB] = pll_output_divide_field_ff;
        end
        `SCSS_OFF_PRESC: nxt_rdata[`SCSS_PRESC_MSB:`SCSS_PRESC_LSB] = prescaler_divide_field_ff;
        `SCSS_OFF_STATUS: begin
          nxt_rdata[`SCSS_ST_SEL_MSB:`SCSS_ST_SEL_LSB] = act_sel_ff;
          nxt_rdata[`SCSS_ST_BYP_BIT]                  = act_byp_ff;
          nxt_rdata[`SCSS_ST_PEND_BIT]                 = cfg_diff;
          nxt_rdata[`SCSS_ST_CLK_BIT]                  = sys_clk_ff;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

endmodule

`default_nettype wire

// *** testbench/scss_src_model.sv ***
// Free-running model of one clock source feeding the selector.
// Assumes high and low times in clk_i cycles, each at least 2.
`timescale 1ns/100ps
`default_nettype none

module scss_src_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] high_i,
  input  wire logic [7:0] low_i,
  output logic            clk_o
);
  // ****************************************
  // Oscillator
  // ****************************************
  logic [7:0] cnt_ff;

  // Oscillators run free, so no idle level between uses
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clk_o  <= 1'b0;
      cnt_ff <= 8'h01;
    end else if (cnt_ff >= (clk_o ? high_i : low_i)) begin
      clk_o  <= ~clk_o;
      cnt_ff <= 8'h01;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule

`default_nettype wire

// *** testbench/scss_clock_select_assertions.sv ***
// Port checks for the clock source selector.
// Assumes source levels last 2+ cycles; PLL output is rate-checked by the bench only.
`timescale 1ns/100ps
`default_nettype none

module scss_clock_select_chk (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] rdata_o,
  input  wire logic        direct_clock_input_pin_i,
  input  wire logic        crystal_input_pin_i,
  input  wire logic        internal_clock_i,
  input  wire logic        wakeup_clock_i,
  input  wire logic        sys_clk_o
);
  // ****************************************
  // Shadow of software writes and source activity
  // ****************************************
  logic [3:0] src;
  logic [3:0] src_q_ff;
  logic [2:0] idle_ff;
  logic [9:0] quiet_ff;
  logic [1:0] sel_ff;
  logic       wrote_ff;
  logic       pll_ff;
  logic       cfg_wr;

  assign src    = {wakeup_clock_i, internal_clock_i, crystal_input_pin_i, direct_clock_input_pin_i};
  assign cfg_wr = wr_i && (addr_i <= 8'h08);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      src_q_ff <= 4'h0;
      idle_ff  <= 3'h7;
      quiet_ff <= 10'h000;
      sel_ff   <= 2'h0;
      wrote_ff <= 1'b0;
      pll_ff   <= 1'b0;
    end else begin
      src_q_ff <= src;
      idle_ff  <= (src != src_q_ff) ? 3'h0 : idle_ff + {2'h0, idle_ff != 3'h7};
      quiet_ff <= cfg_wr ? 10'h000 : quiet_ff + {9'h000, !quiet_ff[9]};
      wrote_ff <= wrote_ff || cfg_wr;
      pll_ff   <= pll_ff || (wr_i && addr_i == 8'h04 && !wdata_i[0]);
      if (wr_i && addr_i == 8'h00) begin
        sel_ff <= wdata_i[1:0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ****************************************
  // Checks
  // ****************************************
  property p_rst_low;
    $rose(rst_b_i) |-> !sys_clk_o;
  endproperty
  property p_cause;
    !pll_ff && $changed(sys_clk_o) |-> idle_ff < 3'h7;
  endproperty
  property p_high_wide;
    !pll_ff && $rose(sys_clk_o) |=> sys_clk_o;
  endproperty
  property p_low_wide;
    !pll_ff && $fell(sys_clk_o) |=> !sys_clk_o;
  endproperty
  property p_wake_rise;
    !wrote_ff && $rose(wakeup_clock_i) |-> ##[4:6] $rose(sys_clk_o);
  endproperty
  property p_wake_fall;
    !wrote_ff && $fell(wakeup_clock_i) |-> ##[4:6] $fell(sys_clk_o);
  endproperty
  property p_dir_rise;
    sel_ff == 2'h3 && quiet_ff[9] && $rose(direct_clock_input_pin_i) |-> ##[4:6] $rose(sys_clk_o);
  endproperty
  property p_dir_fall;
    sel_ff == 2'h3 && quiet_ff[9] && $fell(direct_clock_input_pin_i) |-> ##[4:6] $fell(sys_clk_o);
  endproperty

  a_rst_low: assert property (p_rst_low) else $error("sys clock high after reset");
  a_cause: assert property (p_cause) else $error("sys clock moved without source edge");
  a_high_wide: assert property (p_high_wide) else $error("runt high phase");
  a_low_wide: assert property (p_low_wide) else $error("runt low phase");
  a_wake_rise: assert property (p_wake_rise) else $error("wakeup rise lost");
  a_wake_fall: assert property (p_wake_fall) else $error("wakeup fall lost");
  a_dir_rise: assert property (p_dir_rise) else $error("direct rise lost");
  a_dir_fall: assert property (p_dir_fall) else $error("direct fall lost");

  c_wake: cover property ($rose(wakeup_clock_i) ##5 $rose(sys_clk_o));
  c_direct: cover property (sel_ff == 2'h3 && quiet_ff[9] && $rose(sys_clk_o));
  c_pll: cover property (pll_ff && $rose(sys_clk_o));
endmodule

bind scss_clock_select scss_clock_select_chk u_chk (
  .clk_i                    (clk_i),
  .rst_b_i                  (rst_b_i),
  .addr_i                   (addr_i),
  .wdata_i                  (wdata_i),
  .wr_i                     (wr_i),
  .rd_i                     (rd_i),
  .rdata_o                  (rdata_o),
  .direct_clock_input_pin_i (direct_clock_input_pin_i),
  .crystal_input_pin_i      (crystal_input_pin_i),
  .internal_clock_i         (internal_clock_i),
  .wakeup_clock_i           (wakeup_clock_i),
  .sys_clk_o                (sys_clk_o)
);

`default_nettype wire

// *** testbench/scss_clock_select_tb.sv ***
// Self-checking bench for the clock source selector.
// Assumes free-running sources with fixed high and low times.
`timescale 1ns/100ps
`default_nettype none

module scss_clock_select_tb;
  logic        clk_i;
  logic        rst_b_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        sys_clk_o;
  wire  [3:0]  src_w;
  logic [7:0]  hi_q [4];
  logic [7:0]  lo_q [4];
  int          failures;
  int          n_tests;

  for (genvar g = 0; g < 4; g++) begin : g_src
    scss_src_model u_src (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .high_i  (hi_q[g]),
      .low_i   (lo_q[g]),
      .clk_o   (src_w[g])
    );
  end

  scss_clock_select dut (
    .clk_i                    (clk_i),
    .rst_b_i                  (rst_b_i),
    .addr_i                   (addr_i),
    .wdata_i                  (wdata_i),
    .wr_i                     (wr_i),
    .rd_i                     (rd_i),
    .rdata_o                  (rdata_o),
    .direct_clock_input_pin_i (src_w[0]),
    .crystal_input_pin_i      (src_w[1]),
    .internal_clock_i         (src_w[2]),
    .wakeup_clock_i           (src_w[3]),
    .sys_clk_o                (sys_clk_o)
  );

  // ****************************************
  // Bus and measurement helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Switch waits for the old source, so poll the pending flag
  task automatic cfg(input logic [31:0] pll, input logic [31:0] presc);
    logic [31:0] s;
    wr(8'h04, pll);
    wr(8'h08, presc);
    s = 32'h8;
    for (int i = 0; i < 6000 && s[3]; i++) rd(8'h0C, s);
    check(s & 32'h8, 32'h0);
  endtask

  // First high time and total length of n periods, sampled mid-cycle
  task automatic measure(input int n, output int hi, output int tot);
    int g;
    hi = 0;
    tot = 0;
    g = 0;
    while (sys_clk_o !== 1'b0 && g < 20000) begin @(negedge clk_i); g++; end
    while (sys_clk_o !== 1'b1 && g < 20000) begin @(negedge clk_i); g++; end
    for (int k = 0; k < n; k++) begin
      while (sys_clk_o === 1'b1 && g < 20000) begin @(negedge clk_i); g++; tot++; hi += (k == 0); end
      while (sys_clk_o !== 1'b1 && g < 20000) begin @(negedge clk_i); g++; tot++; end
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_wakeup();
    int h, p;
    measure(1, h, p);
    check(32'(h), 32'hA);
    check(32'(p), 32'h14);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h0C, 32'hFFFF_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h00, d);
    check(d, 32'h0);
    rd(8'h04, d);
    check(d, 32'h1);
    rd(8'h08, d);
    check(d, 32'h3FF);
    rd(8'h40, d);
    check(d, 32'h0);
    rd(8'h0C, d);
    check(d & 32'h7, 32'h4);
  endtask

  task automatic t_direct();
    int h, p;
    wr(8'h00, 32'h3);
    cfg(32'h1, 32'h3FF);
    repeat (600) @(posedge clk_i);
    measure(1, h, p);
    check(32'(h), 32'h4);
    check(32'(p), 32'hC);
  endtask

  task automatic t_crystal_one();
    int h, p;
    wr(8'h00, 32'h2);
    cfg(32'h1, 32'h0);
    measure(1, h, p);
    check(32'(h), 32'h3);
    check(32'(p), 32'h8);
  endtask

  task automatic t_internal_four();
    int h, p;
    cfg(32'h3, 32'h3);
    measure(1, h, p);
    check(32'(h), 32'h18);
    check(32'(p), 32'h30);
  endtask

  task automatic t_max_factor();
    int h, p;
    cfg(32'h1, 32'h3FF);
    measure(1, h, p);
    check(32'(h), 32'h1000);
    check(32'(p), 32'h2000);
  endtask

  task automatic t_pll();
    int h, p;
    cfg(32'h1, 32'h0);
    cfg(32'h20C0, 32'h0);
    repeat (100) @(posedge clk_i);
    measure(8, h, p);
    check(32'(p >= 31 && p <= 33), 32'h1);
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    #400000;
    failures++;
    print_verdict();
  end

  initial begin
    hi_q = '{8'h04, 8'h03, 8'h06, 8'h0A};
    lo_q = '{8'h08, 8'h05, 8'h06, 8'h0A};
    failures = 0;
    n_tests = 0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rst_b_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_wakeup();
    t_regs();
    t_direct();
    t_crystal_one();
    t_internal_four();
    t_max_factor();
    t_pll();
    print_verdict();
  end
endmodule

`default_nettype wire
